// file: verilog/ims_master_status.sv
// Master status, byte engine and own-address match for the two-wire controller
// Notes on behaviour
// - The transfer event flag (status bit 0) sets when a byte completes or arbitration is lost.
// - The interrupt line is high while the transfer event flag is set and its enable is 1.
// - Transfer-in-progress (bit 1) is 1 while a master byte transfer runs, 0 once it ends and any requested STOP has been sent.
// - A reload request starts an EEPROM reload; reload status (bit 3) is 1 until it is done.
// - Loader-done (bit 4) is 1 once loading has finished and 0 while it is under way.
// - Arbitration-lost (bit 5) sets on a STOP seen on the bus while this master sends a START or a byte.
// - Arbitration-lost also sets when this master releases SDA high but samples it low.
// - Bus busy (bit 6) sets after a START on the bus and clears after a STOP.
// - Bit 7 records the slave acknowledge after a byte, 1 for NACK, valid once transfer ends.
// - The own address is the high field (bits 9:8) above the low byte (bits 7:0).
// - In 7-bit addressing only address bits 6..0 are compared, bit 6 most significant.
// - In 10-bit addressing address bits 9..0 are compared, bit 9 most significant.
`timescale 1ns/100ps
module ims_master_status #(
   parameter int QUARTER_CYCLES = ims_pkg::QUARTER,
   parameter int LOAD_CYCLES = ims_pkg::LOAD_DEFAULT
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write channels
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Two-wire bus pins, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Status outputs
   output logic controller_irq_line,
   output logic addr_match
);
   typedef struct packed {
      logic awready, wready, bvalid, aw_have, w_have, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [5:0] aw_idx;
      logic [15:0] wd;
      logic [1:0] ws;
      logic [31:0] rdata;
      logic ten, flag_if, flag_al, flag_ack, busy, reload_status, loader_done, stop_req;
      logic [7:0] mask, cmd_data;
      logic [9:0] own_addr;
      logic [15:0] load_cnt;
      ims_pkg::ims_eng_t eng;
      logic [9:0] qcnt;
      logic [1:0] phase;
      logic [3:0] bitn;
      logic [7:0] shreg;
      logic scl_oe, sda_oe, scl_d, sda_d;
      logic [7:0] mon_shift;
      logic [3:0] mon_cnt;
      logic [1:0] mon_byte;
      logic mon_hi_ok, match, irq;
   } ims_state_t;

   ims_state_t s;
   ims_state_t next_s;
   logic [1:0] pins_s;
   logic scl_s, sda_s, tick, start_det, stop_det, scl_rise;
   logic ev_done, ev_al, ack_ev, msr_rd, go_write, reload_go, sda_lost;
   logic [7:0] msr_val, nsh;

   // Pins come from outside the clock domain
   ims_sync2 #(.W(2)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({scl_in, sda_in}),
      .dout(pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // Live status view; transfer-in-progress follows the engine
   assign msr_val = {s.flag_ack, s.busy, s.flag_al, s.loader_done, s.reload_status, 1'b0,
                     s.eng != ims_pkg::E_IDLE, s.flag_if};

   // Next-state logic for bus slave, engine, monitor and flags
   always_comb
   begin
      next_s = s;
      ev_done = 1'b0;
      ev_al = 1'b0;
      ack_ev = 1'b0;
      go_write = 1'b0;
      reload_go = 1'b0;
      sda_lost = 1'b0;
      msr_rd = 1'b0;
      next_s.scl_d = scl_s;
      next_s.sda_d = sda_s;
      scl_rise = scl_s & ~s.scl_d;
      start_det = s.scl_d & scl_s & s.sda_d & ~sda_s;
      stop_det = s.scl_d & scl_s & ~s.sda_d & sda_s;
      tick = (s.qcnt == 10'(QUARTER_CYCLES - 1));
      nsh = {s.mon_shift[6:0], sda_s};

      // Write channel: address and data taken in either order
      if (s.awready && s_axi_awvalid)
      begin
         next_s.aw_have = 1'b1;
         next_s.aw_idx = s_axi_awaddr[7:2];
      end
      if (s.wready && s_axi_wvalid)
      begin
         next_s.w_have = 1'b1;
         next_s.wd = s_axi_wdata[15:0];
         next_s.ws = s_axi_wstrb[1:0];
      end
      if (s.aw_have && s.w_have && !s.bvalid)
      begin
         next_s.aw_have = 1'b0;
         next_s.w_have = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp = ims_pkg::RESP_OKAY;
         unique case (s.aw_idx)
            ims_pkg::IDX_CTRL:
               if (s.ws[0])
               begin
                  next_s.ten = s.wd[ims_pkg::C_TEN];
                  reload_go = s.wd[ims_pkg::C_RELOAD] & ~s.reload_status;
               end
            ims_pkg::IDX_CMD:
            begin
               if (s.ws[0])
                  next_s.cmd_data = s.wd[7:0];
               go_write = s.ws[1] & s.wd[ims_pkg::K_GO] & (s.eng == ims_pkg::E_IDLE);
            end
            ims_pkg::IDX_MASK:
               if (s.ws[0])
                  next_s.mask = s.wd[7:0];
            ims_pkg::IDX_SDA:
            begin
               if (s.ws[0])
                  next_s.own_addr[7:0] = s.wd[7:0];
               if (s.ws[1])
                  next_s.own_addr[9:8] = s.wd[9:8];
            end
            ims_pkg::IDX_MSR: ;
            default: next_s.bresp = ims_pkg::RESP_SLVERR;
         endcase
      end
      if (s.bvalid && s_axi_bready)
         next_s.bvalid = 1'b0;
      // Ready again only once the previous response has gone
      next_s.awready = ~next_s.aw_have & ~next_s.bvalid & ~(s.awready & s_axi_awvalid);
      next_s.wready = ~next_s.w_have & ~next_s.bvalid & ~(s.wready & s_axi_wvalid);

      // Read channel; a status read has a clearing side effect
      if (s.arready && s_axi_arvalid)
      begin
         next_s.rvalid = 1'b1;
         next_s.rresp = ims_pkg::RESP_OKAY;
         unique case (s_axi_araddr[7:2])
            ims_pkg::IDX_CTRL: next_s.rdata = {27'h0, s.reload_status, 3'h0, s.ten};
            ims_pkg::IDX_CMD: next_s.rdata = {21'h0, s.eng != ims_pkg::E_IDLE,
                                              s.stop_req, 1'b0, s.cmd_data};
            ims_pkg::IDX_MASK: next_s.rdata = {24'h0, s.mask};
            ims_pkg::IDX_SDA: next_s.rdata = {22'h0, s.own_addr};
            ims_pkg::IDX_MSR:
            begin
               next_s.rdata = {24'h0, msr_val};
               msr_rd = 1'b1;
            end
            default:
            begin
               next_s.rdata = 32'h0;
               next_s.rresp = ims_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.rvalid && s_axi_rready)
         next_s.rvalid = 1'b0;
      next_s.arready = ~next_s.rvalid;

      // Byte engine: four quarter-periods per SCL bit
      if (s.eng != ims_pkg::E_IDLE)
      begin
         next_s.qcnt = tick ? 10'h000 : s.qcnt + 10'h001;
         if (tick)
            next_s.phase = s.phase + 2'h1;
      end
      unique case (s.eng)
         ims_pkg::E_IDLE:
            if (go_write)
            begin
               next_s.qcnt = 10'h000;
               next_s.phase = 2'h0;
               next_s.bitn = 4'h0;
               next_s.shreg = next_s.cmd_data;
               next_s.stop_req = s.wd[ims_pkg::K_STOP];
               next_s.sda_oe = 1'b0;
               if (s.wd[ims_pkg::K_START])
                  next_s.eng = ims_pkg::E_START;
               else
               begin
                  next_s.eng = ims_pkg::E_BITS;
                  next_s.scl_oe = 1'b1;
               end
            end
         ims_pkg::E_START:
            if (tick)
               unique case (s.phase)
                  2'h0: next_s.scl_oe = 1'b0;
                  2'h1: next_s.sda_oe = 1'b1;
                  2'h2: next_s.scl_oe = 1'b1;
                  2'h3: next_s.eng = ims_pkg::E_BITS;
               endcase
         ims_pkg::E_BITS:
            if (tick)
               unique case (s.phase)
                  2'h0: next_s.sda_oe = (s.bitn == ims_pkg::ACK_BIT) ? 1'b0 : ~s.shreg[7];
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2:
                     if (s.bitn == ims_pkg::ACK_BIT)
                        ack_ev = 1'b1;
                     else if (!s.sda_oe && !sda_s)
                        sda_lost = 1'b1;
                  2'h3:
                  begin
                     next_s.scl_oe = 1'b1;
                     if (s.bitn == ims_pkg::ACK_BIT)
                     begin
                        ev_done = 1'b1;
                        next_s.eng = s.stop_req ? ims_pkg::E_STOP : ims_pkg::E_IDLE;
                     end
                     else
                     begin
                        next_s.bitn = s.bitn + 4'h1;
                        next_s.shreg = {s.shreg[6:0], 1'b0};
                     end
                  end
               endcase
         ims_pkg::E_STOP:
            if (tick)
               unique case (s.phase)
                  2'h0: next_s.sda_oe = 1'b1;
                  2'h1: next_s.scl_oe = 1'b0;
                  2'h2: next_s.sda_oe = 1'b0;
                  2'h3: next_s.eng = ims_pkg::E_IDLE;
               endcase
      endcase

      // Lost bus: a foreign STOP mid-transfer or SDA pulled low under us
      ev_al = sda_lost | (stop_det & (s.eng == ims_pkg::E_START
                                      || s.eng == ims_pkg::E_BITS));
      if (ev_al)
      begin
         next_s.eng = ims_pkg::E_IDLE;
         next_s.scl_oe = 1'b0;
         next_s.sda_oe = 1'b0;
      end

      // Sticky flags: a read clears, a same-cycle event wins
      next_s.flag_if = (s.flag_if & ~msr_rd) | ev_done | ev_al;
      next_s.flag_al = (s.flag_al & ~msr_rd) | ev_al;
      if (ack_ev)
         next_s.flag_ack = sda_s;
      else if (msr_rd)
         next_s.flag_ack = 1'b0;

      // Bus busy tracks START and STOP seen on the pins
      if (start_det)
         next_s.busy = 1'b1;
      else if (stop_det)
         next_s.busy = 1'b0;

      // Reload sequencer; the EEPROM read is timed, not parsed here
      if (reload_go)
      begin
         next_s.reload_status = 1'b1;
         next_s.loader_done = 1'b0;
         next_s.load_cnt = 16'(LOAD_CYCLES);
      end
      else if (s.load_cnt != 16'h0000)
      begin
         next_s.load_cnt = s.load_cnt - 16'h0001;
         if (s.load_cnt == 16'h0001)
         begin
            next_s.reload_status = 1'b0;
            next_s.loader_done = 1'b1;
         end
      end

      // Address monitor: nine SCL rises per byte, ninth is the acknowledge
      if (start_det || stop_det)
      begin
         next_s.mon_cnt = 4'h0;
         next_s.mon_byte = 2'h0;
         next_s.mon_hi_ok = 1'b0;
         next_s.match = 1'b0;
      end
      else if (scl_rise)
      begin
         if (s.mon_cnt == ims_pkg::ACK_BIT)
         begin
            next_s.mon_cnt = 4'h0;
            if (s.mon_byte != 2'h2)
               next_s.mon_byte = s.mon_byte + 2'h1;
         end
         else
         begin
            next_s.mon_shift = nsh;
            next_s.mon_cnt = s.mon_cnt + 4'h1;
            if (s.mon_cnt == ims_pkg::LAST_DATA_BIT && s.mon_byte == 2'h0)
            begin
               if (s.ten)
                  next_s.mon_hi_ok = (nsh[7:3] == ims_pkg::TEN_PREFIX)
                                     && (nsh[2:1] == s.own_addr[9:8]);
               else
                  next_s.match = (nsh[7:1] == s.own_addr[6:0]);
            end
            if (s.mon_cnt == ims_pkg::LAST_DATA_BIT && s.mon_byte == 2'h1 && s.ten)
               next_s.match = s.mon_hi_ok && (nsh == s.own_addr[7:0]);
         end
      end

      // Interrupt: unmasked sticky bits; mask bits 0, 5 and 7 enable the event, lost and acknowledge flags
      next_s.irq = |({next_s.flag_ack, 1'b0, next_s.flag_al, 4'h0, next_s.flag_if}
                     & next_s.mask);
   end

   // Single state register; status resets to loader-done only
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s <= '0;
         s.loader_done <= ims_pkg::MSR_RESET[ims_pkg::B_BLD];
         s.mask <= ims_pkg::MASK_RESET;
         s.own_addr <= ims_pkg::SDA_RESET;
         s.eng <= ims_pkg::E_IDLE;
         s.scl_d <= 1'b1;
         s.sda_d <= 1'b1;
      end
      else
         s <= next_s;
   end

   // Port drive; open-drain pins only ever pull low
   assign s_axi_awready = s.awready;
   assign s_axi_wready = s.wready;
   assign s_axi_bresp = s.bresp;
   assign s_axi_bvalid = s.bvalid;
   assign s_axi_arready = s.arready;
   assign s_axi_rdata = s.rdata;
   assign s_axi_rresp = s.rresp;
   assign s_axi_rvalid = s.rvalid;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = s.scl_oe;
   assign sda_oe = s.sda_oe;
   assign controller_irq_line = s.irq;
   assign addr_match = s.match;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_done_sets_flag: assert property (ev_done |=> s.flag_if)
      else $error("byte completion did not set the event flag");
   // A status read or a register write in that cycle may legally drop the line
   a_irq_gated: assert property (s.flag_if && s.mask[0] && !msr_rd
                                 && !(s.aw_have && s.w_have) |=> controller_irq_line)
      else $error("interrupt missing with flag and enable set");
   a_tip_on_go: assert property (go_write
                                 |=> msr_val[ims_pkg::B_TIP] ##1 msr_val[ims_pkg::B_TIP])
      else $error("transfer in progress not raised on go");
   a_reload_runs: assert property (reload_go |=> s.reload_status && !s.loader_done)
      else $error("reload did not raise reload status");
   a_reload_ends: assert property (s.reload_status && s.load_cnt == 16'h0001 |=> !s.reload_status && s.loader_done)
      else $error("reload end did not restore loader done");
   a_stop_lost: assert property (stop_det && s.eng == ims_pkg::E_BITS
                                 |=> s.flag_al && s.eng == ims_pkg::E_IDLE)
      else $error("foreign stop did not flag arbitration loss");
   a_sda_lost: assert property (sda_lost |=> s.flag_al && !s.sda_oe && !s.scl_oe)
      else $error("sda conflict did not flag arbitration loss");
   a_busy_track: assert property (start_det |=> s.busy)
      else $error("start did not set bus busy");
   a_busy_clear: assert property (stop_det && !start_det |=> !s.busy)
      else $error("stop did not clear bus busy");
   a_ack_capture: assert property (ack_ev |=> s.flag_ack == $past(sda_s))
      else $error("acknowledge not recorded");
   a_reset_value: assert property (!$past(aresetn) |-> msr_val == ims_pkg::MSR_RESET)
      else $error("status reset value wrong");
   a_read_clears: assert property (msr_rd && !ev_done && !ev_al && !ack_ev
                                   |=> !s.flag_if && !s.flag_al && !s.flag_ack)
      else $error("status read did not clear flags");

   c_byte_done: cover property (ev_done);
   c_arb_lost: cover property (ev_al);
   c_addr_hit: cover property ($rose(s.match));
   c_reload: cover property (reload_go ##1 s.reload_status);
endmodule : ims_master_status

// file: verilog/ims_pkg.sv
// Constants and encodings shared by the master status and own-address block
package ims_pkg;

   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_CTRL = 6'h01;
   localparam logic [5:0] IDX_CMD = 6'h03;
   localparam logic [5:0] IDX_MASK = 6'h04;
   localparam logic [5:0] IDX_MSR = 6'h06;
   localparam logic [5:0] IDX_SDA = 6'h08;

   // Master status bit positions
   localparam int B_IF = 0;
   localparam int B_TIP = 1;
   localparam int B_RELOAD_STATUS = 3;
   localparam int B_BLD = 4;
   localparam int B_AL = 5;
   localparam int B_BUSY = 6;
   localparam int B_ACK = 7;

   // Control and command bit positions
   localparam int C_TEN = 0;
   localparam int C_RELOAD = 4;
   localparam int K_START = 8;
   localparam int K_STOP = 9;
   localparam int K_GO = 10;

   // Reset values and widths
   localparam logic [7:0] MSR_RESET = 8'h10;
   localparam logic [9:0] SDA_RESET = 10'h000;
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [4:0] TEN_PREFIX = 5'h1e;
   localparam logic [3:0] ACK_BIT = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;

   // Timing
   localparam int CLK_HZ = 200_000_000;
   localparam int SCL_HZ = 100_000;
   localparam int QUARTER = CLK_HZ / (4 * SCL_HZ);
   localparam int LOAD_DEFAULT = 1024;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Byte engine states, Gray along idle-start-bits-stop-idle
   typedef enum logic [1:0] {
      E_IDLE = 2'h0,
      E_START = 2'h1,
      E_BITS = 2'h3,
      E_STOP = 2'h2
   } ims_eng_t;

endpackage : ims_pkg

// file: verilog/ims_sync2.sv
// Two-stage synchroniser for the bus pins
`timescale 1ns/100ps
module ims_sync2 #(
   parameter int W = 2
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Data
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } ims_sync_t;

   ims_sync_t s;
   ims_sync_t next_s;

   // Only the second stage looks at the first
   always_comb
   begin
      next_s.s1 = din;
      next_s.s2 = s.s1;
   end

   // Idle bus lines float high, so reset to ones
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         s <= '{s1: '1, s2: '1};
      else
         s <= next_s;
   end

   assign dout = s.s2;
endmodule : ims_sync2

// file: tb/ims_tb_slave.sv
// Behavioural two-wire slave that acknowledges, refuses or disturbs the data line
`timescale 1ns/100ps
module ims_tb_slave (
   // Bus wire levels
   input wire logic scl,
   input wire logic sda,
   // Behaviour controls
   input wire logic nack,
   input wire logic arb,
   input wire logic cut,
   // Pull-down on the data line, pull-up elsewhere
   output logic pull
);
   int cnt = 0;

   initial pull = 1'b0;

   // A START restarts the bit count; a restart does the same
   always @(negedge sda)
   begin
      if (scl)
         cnt = 0;
   end

   // One count per rising clock: eight data bits, then the acknowledge;
   // a cut frame lets go of the acknowledge while SCL is high, a foreign STOP
   always @(posedge scl)
   begin
      cnt = cnt + 1;
      if (cut && cnt == 9)
         pull <= #12 1'b0;
   end

   // Data changes here only while the clock is low; only the cut frame's release fakes a STOP
   always @(negedge scl)
   begin
      if (cnt == 9)
         cnt = 0;
      pull <= (cnt == 8 && !nack) || (arb && cnt < 8);
   end
endmodule : ims_tb_slave

// file: tb/tb_ims_master_status.sv
// Self-checking bench for the master status and own-address block
`timescale 1ns/100ps
module tb_ims_master_status;
   localparam int QC = 4;
   localparam int LC = 8;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v, d;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic scl_out, scl_oe, sda_out, sda_oe, controller_irq_line, addr_match;
   logic pull, nack = 1'b0, arb = 1'b0, cut = 1'b0;
   logic [9:0] a;
   logic [12:0] q[$];
   int num_errors = 0, tests_run = 0, m_busy = 0;
   wire scl_w, sda_w;

   // Open-drain wires with pull-ups: a released line reads high
   assign scl_w = scl_oe ? scl_out : 1'b1;
   assign sda_w = (sda_oe ? sda_out : 1'b1) & ~pull;

   // 200 MHz clock
   always #2.5 aclk = ~aclk;

   ims_master_status #(.QUARTER_CYCLES(QC), .LOAD_CYCLES(LC)) u_ims_master_status (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe),
      .controller_irq_line(controller_irq_line), .addr_match(addr_match));

   ims_tb_slave u_ims_tb_slave (.scl(scl_w), .sda(sda_w), .nack(nack), .arb(arb), .cut(cut),
      .pull(pull));

   task automatic stop_test();
      $display("tests_run %0d num_errors %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test

   task automatic tmo();
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
   endtask : tmo

   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string m);
      tests_run++;
      if (s !== e)
      begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, m, s, e);
      end
   endtask : chk

   // Write: both channels offered together, each dropped once taken
   task automatic axw(input logic [7:0] ad, input logic [31:0] wd);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 200; n++)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      if (n == 200)
         tmo();
   endtask : axw

   // Read: data and response taken at the edge where rvalid is seen
   task automatic axr(input logic [7:0] ad);
      int n;
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 200; n++)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      if (n == 200)
         tmo();
   endtask : axr

   // Issue one byte command and wait for the completion interrupt
   task automatic go(input logic [7:0] db, input logic sta, input logic sto);
      int n;
      axw({ims_pkg::IDX_CMD, 2'b00}, {21'h0, 1'b1, sto, sta, db});
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v[ims_pkg::B_TIP], 1'b1, "busy transfer");
      for (n = 0; n < 4000 && controller_irq_line !== 1'b1; n++)
         @(posedge aclk);
      if (n == 4000)
         tmo();
      // STOP takes four quarters plus the pin synchroniser
      repeat (20 * QC) @(posedge aclk);
   endtask : go

   // Main sequence
   initial
   begin
      void'($urandom(95682));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v, 32'h10, "status reset");
      axr({ims_pkg::IDX_SDA, 2'b00});
      chk(v, 32'h0, "address reset");
      axw({ims_pkg::IDX_MSR, 2'b00}, 32'hff);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v, 32'h10, "status read only");
      axw(8'h3c, 32'h1);
      chk(r, ims_pkg::RESP_SLVERR, "unmapped write");
      axr(8'h3c);
      chk(v, 32'h0, "unmapped read");
      chk(r, ims_pkg::RESP_SLVERR, "unmapped read response");
      a = 10'($urandom);
      d = $urandom;
      axw({ims_pkg::IDX_SDA, 2'b00}, {d[31:10], a});
      axr({ims_pkg::IDX_SDA, 2'b00});
      chk(v, {22'h0, a}, "own address");
      chk(r, ims_pkg::RESP_OKAY, "read response");
      axw({ims_pkg::IDX_MASK, 2'b00}, 32'h1);
      $display("test registers done");
      // Frame table: mode, match, nack, stop, start, byte
      q.push_back({5'b01001, a[6:0], 1'b0});
      q.push_back({5'b00110, 8'($urandom)});
      q.push_back({5'b00001, a[6:0] ^ 7'h01, 1'b0});
      q.push_back({5'b10001, ims_pkg::TEN_PREFIX, a[9:8], 1'b0});
      q.push_back({5'b11000, a[7:0]});
      q.push_back({5'b10110, 8'($urandom)});
      foreach (q[i])
      begin
         axw({ims_pkg::IDX_CTRL, 2'b00}, {31'h0, q[i][12]});
         nack <= q[i][10];
         go(q[i][7:0], q[i][8], q[i][9]);
         m_busy = q[i][8] ? 1 : (q[i][9] ? 0 : m_busy);
         chk(addr_match, q[i][11], "address match");
         axr({ims_pkg::IDX_MSR, 2'b00});
         chk(v, {24'h0, q[i][10], m_busy[0], 6'h11}, "byte status");
         repeat (2) @(posedge aclk);
         chk(controller_irq_line, 1'b0, "irq after read");
      end
      $display("test frames done");
      // Foreign STOP inside the acknowledge bit of a running byte
      nack <= 1'b0;
      cut <= 1'b1;
      go(8'($urandom), 1'b1, 1'b0);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v, 32'h31, "foreign stop");
      cut <= 1'b0;
      $display("test foreign stop done");
      // Lost arbitration on the first released data bit
      arb <= 1'b1;
      go(8'hff, 1'b1, 1'b0);
      axw({ims_pkg::IDX_MASK, 2'b00}, 32'h0);
      repeat (2) @(posedge aclk);
      chk(controller_irq_line, 1'b0, "irq masked");
      axw({ims_pkg::IDX_MASK, 2'b00}, 32'h1);
      repeat (2) @(posedge aclk);
      chk(controller_irq_line, 1'b1, "irq enabled");
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v & 32'h23, 32'h21, "arbitration");
      arb <= 1'b0;
      repeat (20 * QC) @(posedge aclk);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v & 32'h21, 32'h0, "flags cleared");
      $display("test arbitration done");
      // Reload: status up and loader busy, then both back
      axw({ims_pkg::IDX_CTRL, 2'b00}, 32'h10);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v & 32'h18, 32'h08, "reload running");
      repeat (4 * LC) @(posedge aclk);
      axr({ims_pkg::IDX_MSR, 2'b00});
      chk(v & 32'h18, 32'h10, "reload finished");
      $display("test reload done");
      stop_test();
   end
endmodule : tb_ims_master_status
